// [verilog/mpcp_codec_pkg.sv]
// shared constants and carriers for the head-end control frame codec
// assumes one clock, octet-wide streams, frames begin with the opcode on rx
package mpcp_codec_pkg;
  localparam logic [15:0] OPC_REPORT = 16'h0003;
  localparam logic [15:0] OPC_REG_REQ = 16'h0004;
  localparam logic [15:0] OPC_REGISTER = 16'h0005;
  localparam logic [7:0] REQ_FLAG_REGISTER = 8'h01;
  localparam logic [7:0] REQ_FLAG_DEREGISTER = 8'h03;
  localparam logic [7:0] REG_FLAG_REREGISTER = 8'h01;
  localparam logic [7:0] REG_FLAG_DEREGISTER = 8'h02;
  localparam logic [7:0] REG_FLAG_ACK = 8'h03;
  localparam logic [7:0] REG_FLAG_NACK = 8'h04;
  localparam int CAP_UP_1G = 0;
  localparam int CAP_UP_10G = 1;
  localparam int CAP_TRY_1G = 4;
  localparam int CAP_TRY_10G = 5;
  localparam int MAP_W = 8;
  localparam int QLEN_W = 16;
  localparam int POS_W = 6;
  localparam int DA_LEN = 6;
  localparam int OP_LEN = 2;
  localparam int TS_LEN = 4;
  localparam int PAYLOAD_LEN = 40;
  localparam int HDR_LEN = OP_LEN + TS_LEN;
  localparam int RX_LEN = HDR_LEN + PAYLOAD_LEN;
  localparam int TX_OP_POS = DA_LEN;
  localparam int TX_TS_POS = TX_OP_POS + OP_LEN;
  localparam int TX_PL_POS = TX_TS_POS + TS_LEN;
  localparam int TX_LEN = TX_PL_POS + PAYLOAD_LEN;
  localparam int REG_PL_LEN = 8;
  localparam int DA_GROUP_BIT = 40;
  localparam int REQ_FLAGS_OFS = 0;
  localparam int REQ_PEND_OFS = 1;
  localparam int REQ_DISC_OFS = 2;
  localparam int REQ_LON_OFS = 4;
  localparam int REQ_LOFF_OFS = 5;

  typedef struct packed {
    logic [47:0] da;
    logic [15:0] port;
    logic [7:0] flag;
    logic [15:0] sync_time;
    logic [7:0] pending;
    logic [7:0] laser_on;
    logic [7:0] laser_off;
  } reg_cmd_t;

  typedef struct packed {
    logic try_10g;
    logic try_1g;
    logic up_10g;
    logic up_1g;
  } cap_t;

  typedef struct packed {
    logic deregister;
    logic [7:0] pending;
    cap_t cap;
    logic [7:0] laser_on;
    logic [7:0] laser_off;
  } req_info_t;

  typedef struct packed {
    logic [7:0] set_idx;
    logic [2:0] queue;
    logic [QLEN_W-1:0] length;
  } rpt_entry_t;

  typedef struct packed {
    logic [7:0] data;
    logic last;
  } byte_beat_t;
endpackage

// [verilog/mpcp_skid_fifo.sv]
// small shift-register fifo with valid/ready on both sides
// assumes one clock and synchronous active-high reset
`timescale 1ns/10ps
`default_nettype none
module mpcp_skid_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 2
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic in_valid,
  input wire logic [WIDTH-1:0] in_data,
  output logic in_ready,
  output logic out_valid,
  output logic [WIDTH-1:0] out_data,
  input wire logic out_ready
);
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [DEPTH-1:0] v;
  } fifo_state_t;

  fifo_state_t cur;
  fifo_state_t next_cur;

  // ready looks only at flops, so no path from out_ready to in_ready
  assign in_ready = ~cur.v[DEPTH-1];
  assign out_valid = cur.v[0];
  assign out_data = cur.mem[0];

  always_comb begin
    logic placed;
    placed = 1'b0;
    next_cur = cur;
    if (cur.v[0] && out_ready) begin
      for (int i = 0; i < DEPTH - 1; i++) begin
        next_cur.mem[i] = cur.mem[i + 1];
        next_cur.v[i] = cur.v[i + 1];
      end
      next_cur.v[DEPTH-1] = 1'b0;
    end
    if (in_valid && !cur.v[DEPTH-1]) begin
      for (int i = 0; i < DEPTH; i++) begin
        if (!placed && !next_cur.v[i]) begin
          next_cur.mem[i] = in_data;
          next_cur.v[i] = 1'b1;
          placed = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      cur <= '0;
    end else begin
      cur <= next_cur;
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  stall_hold_a: assert property (out_valid && !out_ready |=>
    out_valid && $stable(out_data))
    else $error("fifo head changed while stalled");
  empty_pass_a: assert property (in_valid && in_ready && !out_valid |=>
    out_valid && out_data == $past(in_data))
    else $error("word into empty fifo not at head");
endmodule
`default_nettype wire

// [verilog/mpcp_head_codec.sv]
// head-end codec: parses bandwidth reports and registration requests,
// builds registration replies; assumes the mac strips addresses on rx
`timescale 1ns/10ps
`default_nettype none
// Operation
// - report timestamp lets the head end compute round-trip time on arrival.
// - report opcode 0x0003, from an active unit, unicast link id; broadcast reports lose rpt_done and the rpt_rtt update, queue entries still pass.
// - set count says how many bitmap-and-lengths groups follow.
// - 8-bit map, bit n set means queue n length present.
// - each queue length is 16-bit unsigned quanta, present only if mapped.
// - report pad is zero and ignored, 0 to 39 octets.
// - request opcode 0x0004, flag 1 registers, 0, 2, 4-255 ignored.
// - request flag 3 deregisters; unit freed, link id reusable.
// - request carries 8-bit pending grant depth; do not exceed it.
// - capability bits 0, 1 upstream speeds; bits 4, 5 attempts.
// - request carries one-octet laser on and off times in quanta.
// - registration reply goes to an individual address, never a group.
// - reply opcode 0x0005 with 16-bit assigned link id.
// - reply flag 1 reregister, 2 deregister, 3 ack, 4 nack.
// - every frame carries the 32-bit local time at transmission.
// - 40-octet payload region, unused octets zero on send, ignored on receive.
module mpcp_head_codec
  import mpcp_codec_pkg::*;
#(
  parameter int TQ_DIV = 1,
  parameter int BUF_DEPTH = 2
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic cmd_go,
  input wire reg_cmd_t cmd,
  output logic cmd_busy,
  output logic cmd_refused,
  output logic tx_valid,
  output byte_beat_t tx_beat,
  input wire logic tx_ready,
  input wire logic rx_valid,
  input wire byte_beat_t rx_beat,
  input wire logic rx_bcast,
  output logic rpt_valid,
  output rpt_entry_t rpt,
  output logic rpt_done,
  output logic [7:0] rpt_set_count,
  output logic [31:0] rpt_rtt,
  output logic req_valid,
  output req_info_t req,
  output logic [31:0] local_time
);
  typedef enum logic [7:0] {
    RX_OP = 8'h01,
    RX_TS = 8'h02,
    RX_CNT = 8'h04,
    RX_MAP = 8'h08,
    RX_HI = 8'h10,
    RX_LO = 8'h20,
    RX_REQ = 8'h40,
    RX_SKIP = 8'h80
  } rx_state_t;

  typedef enum logic [1:0] {
    TX_IDLE = 2'h1,
    TX_RUN = 2'h2
  } tx_state_t;

  typedef struct packed {
    rx_state_t st;
    logic [POS_W-1:0] pos;
    logic [15:0] opc;
    logic [31:0] ts;
    logic [7:0] sets;
    logic [MAP_W-1:0] map;
    logic [7:0] hi;
    logic [7:0] rq_flag;
    rpt_entry_t rpt;
    logic rpt_valid;
    logic rpt_done;
    logic [7:0] rpt_set_count;
    logic [31:0] rpt_rtt;
    req_info_t req;
    logic req_valid;
    tx_state_t tst;
    logic [POS_W-1:0] tpos;
    reg_cmd_t cmd;
    logic [31:0] tts;
    logic busy;
    logic refused;
    logic [7:0] tq_cnt;
    logic [31:0] local_time;
  } codec_state_t;

  codec_state_t cur;
  codec_state_t next_cur;
  logic tick;
  logic tx_push_ready;
  byte_beat_t tx_in;
  logic tx_push;

  // lowest present queue is reported first
  function automatic logic [2:0] lowest_queue(input logic [MAP_W-1:0] map);
    logic [2:0] q;
    q = 3'h0;
    for (int i = MAP_W - 1; i >= 0; i--) begin
      if (map[i]) begin
        q = 3'(i);
      end
    end
    return q;
  endfunction

  // one octet of the outgoing reply by frame position
  function automatic logic [7:0] tx_octet(input reg_cmd_t c,
      input logic [POS_W-1:0] p, input logic [31:0] ts);
    logic [8*REG_PL_LEN-1:0] pl;
    int k;
    logic [7:0] o;
    pl = {c.port, c.flag, c.sync_time, c.pending, c.laser_on,
      c.laser_off};
    k = int'(p);
    o = 8'h00;
    if (k < TX_OP_POS) begin
      o = c.da[8*(DA_LEN-1-k) +: 8];
    end else if (k < TX_TS_POS) begin
      o = OPC_REGISTER[8*(TX_TS_POS-1-k) +: 8];
    end else if (k < TX_PL_POS) begin
      o = ts[8*(TX_PL_POS-1-k) +: 8];
    end else if (k < TX_PL_POS + REG_PL_LEN) begin
      o = pl[8*(TX_PL_POS+REG_PL_LEN-1-k) +: 8];
    end
    return o;
  endfunction

  assign tick = cur.tq_cnt == 8'(TQ_DIV - 1);
  assign tx_push = (cur.tst == TX_RUN) && tx_push_ready;
  assign tx_in.data = tx_octet(cur.cmd, cur.tpos,
    (cur.tpos == POS_W'(TX_TS_POS)) ? cur.local_time : cur.tts);
  assign tx_in.last = cur.tpos == POS_W'(TX_LEN - 1);

  always_comb begin
    logic [POS_W-1:0] k;
    logic set_end;
    logic [MAP_W-1:0] left;
    k = cur.pos - POS_W'(HDR_LEN);
    set_end = 1'b0;
    left = cur.map;
    next_cur = cur;
    next_cur.rpt_valid = 1'b0;
    next_cur.rpt_done = 1'b0;
    next_cur.req_valid = 1'b0;
    next_cur.refused = 1'b0;
    // time base for stamps and round-trip
    next_cur.tq_cnt = tick ? 8'h00 : cur.tq_cnt + 8'h01;
    if (tick) begin
      next_cur.local_time = cur.local_time + 32'h1;
    end
    if (rx_valid) begin
      if (cur.pos != {POS_W{1'b1}}) begin
        next_cur.pos = cur.pos + POS_W'(1);
      end
      unique case (cur.st)
        RX_OP: begin
          next_cur.opc = {cur.opc[7:0], rx_beat.data};
          if (cur.pos == POS_W'(OP_LEN - 1)) begin
            next_cur.st = RX_TS;
          end
        end
        RX_TS: begin
          next_cur.ts = {cur.ts[23:0], rx_beat.data};
          if (cur.pos == POS_W'(HDR_LEN - 1)) begin
            if (cur.opc == OPC_REPORT) begin
              next_cur.st = RX_CNT;
            end else if (cur.opc == OPC_REG_REQ) begin
              next_cur.st = RX_REQ;
            end else begin
              next_cur.st = RX_SKIP;
            end
          end
        end
        RX_CNT: begin
          next_cur.sets = rx_beat.data;
          next_cur.rpt_set_count = rx_beat.data;
          next_cur.st = (rx_beat.data == 8'h00) ? RX_SKIP : RX_MAP;
        end
        RX_MAP: begin
          next_cur.map = rx_beat.data;
          if (rx_beat.data == 8'h00) begin
            set_end = 1'b1;
          end else begin
            next_cur.st = RX_HI;
          end
        end
        RX_HI: begin
          next_cur.hi = rx_beat.data;
          next_cur.st = RX_LO;
        end
        RX_LO: begin
          next_cur.rpt.queue = lowest_queue(cur.map);
          next_cur.rpt.length = {cur.hi, rx_beat.data};
          // index from sets left, so a set's last entry keeps its own index
          next_cur.rpt.set_idx = cur.rpt_set_count - cur.sets;
          next_cur.rpt_valid = 1'b1;
          left[lowest_queue(cur.map)] = 1'b0;
          next_cur.map = left;
          if (left == '0) begin
            set_end = 1'b1;
          end else begin
            next_cur.st = RX_HI;
          end
        end
        RX_REQ: begin
          case (k)
            POS_W'(REQ_FLAGS_OFS): next_cur.rq_flag = rx_beat.data;
            POS_W'(REQ_PEND_OFS): next_cur.req.pending = rx_beat.data;
            POS_W'(REQ_DISC_OFS): next_cur.hi = rx_beat.data;
            POS_W'(REQ_DISC_OFS + 1): begin
              // reserved capability bits are dropped here
              next_cur.req.cap.up_1g = rx_beat.data[CAP_UP_1G];
              next_cur.req.cap.up_10g = rx_beat.data[CAP_UP_10G];
              next_cur.req.cap.try_1g = rx_beat.data[CAP_TRY_1G];
              next_cur.req.cap.try_10g = rx_beat.data[CAP_TRY_10G];
            end
            POS_W'(REQ_LON_OFS): next_cur.req.laser_on = rx_beat.data;
            POS_W'(REQ_LOFF_OFS): next_cur.req.laser_off = rx_beat.data;
            default: begin
            end
          endcase
        end
        RX_SKIP: begin
          // pad and trailing octets ignored
        end
      endcase
      if (set_end) begin
        next_cur.sets = cur.sets - 8'h01;
        next_cur.st = (cur.sets == 8'h01) ? RX_SKIP : RX_MAP;
      end
      if (rx_beat.last) begin
        next_cur.st = RX_OP;
        next_cur.pos = '0;
        // runt or overlong frames raise no rpt_done or req_valid; queue entries already parsed still pass
        if (cur.pos == POS_W'(RX_LEN - 1)) begin
          if (cur.opc == OPC_REPORT && !rx_bcast) begin
            next_cur.rpt_done = 1'b1;
            next_cur.rpt_rtt = cur.local_time - cur.ts;
          end
          if (cur.opc == OPC_REG_REQ && rx_bcast &&
              (cur.rq_flag == REQ_FLAG_REGISTER ||
               cur.rq_flag == REQ_FLAG_DEREGISTER)) begin
            next_cur.req_valid = 1'b1;
            next_cur.req.deregister =
              cur.rq_flag == REQ_FLAG_DEREGISTER;
          end
        end
      end
    end
    unique case (cur.tst)
      TX_IDLE: begin
        if (cmd_go) begin
          if (cmd.da[DA_GROUP_BIT]) begin
            next_cur.refused = 1'b1;
          end else begin
            next_cur.cmd = cmd;
            next_cur.busy = 1'b1;
            next_cur.tpos = '0;
            next_cur.tst = TX_RUN;
          end
        end
      end
      TX_RUN: begin
        // receiver back-pressure stalls the octet counter
        if (tx_push_ready) begin
          if (cur.tpos == POS_W'(TX_TS_POS)) begin
            next_cur.tts = cur.local_time;
          end
          if (cur.tpos == POS_W'(TX_LEN - 1)) begin
            next_cur.tst = TX_IDLE;
            next_cur.busy = 1'b0;
          end else begin
            next_cur.tpos = cur.tpos + POS_W'(1);
          end
        end
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      cur <= '0;
      cur.st <= RX_OP;
      cur.tst <= TX_IDLE;
    end else begin
      cur <= next_cur;
    end
  end

  mpcp_skid_fifo #(
    .WIDTH($bits(byte_beat_t)),
    .DEPTH(BUF_DEPTH)
  ) tx_buf (
    .clk(clk),
    .rst(rst),
    .in_valid(cur.tst == TX_RUN),
    .in_data(tx_in),
    .in_ready(tx_push_ready),
    .out_valid(tx_valid),
    .out_data(tx_beat),
    .out_ready(tx_ready)
  );

  assign cmd_busy = cur.busy;
  assign cmd_refused = cur.refused;
  assign rpt_valid = cur.rpt_valid;
  assign rpt = cur.rpt;
  assign rpt_done = cur.rpt_done;
  assign rpt_set_count = cur.rpt_set_count;
  assign rpt_rtt = cur.rpt_rtt;
  assign req_valid = cur.req_valid;
  assign req = cur.req;
  assign local_time = cur.local_time;

  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  sequence frame_close;
    !cmd_busy ##0 cur.tst == TX_IDLE;
  endsequence

  sequence refuse_seen;
    cmd_refused ##0 !cmd_busy;
  endsequence

  reply_opcode_a: assert property (
    tx_push && cur.tpos == POS_W'(TX_OP_POS) |->
    tx_in.data == OPC_REGISTER[15:8] ##1 (!tx_push ||
    tx_in.data == OPC_REGISTER[7:0]))
    else $error("reply opcode octets wrong");
  pad_zero_a: assert property (
    tx_push && cur.tpos >= POS_W'(TX_PL_POS + REG_PL_LEN) |->
    tx_in.data == 8'h00)
    else $error("reply pad not zero");
  group_refuse_a: assert property (
    cmd_go && cur.tst == TX_IDLE && cmd.da[DA_GROUP_BIT] |=> refuse_seen)
    else $error("group address not refused");
  frame_end_a: assert property (
    tx_push && tx_in.last |-> cur.tpos == POS_W'(TX_LEN - 1)
    ##1 frame_close)
    else $error("reply length or close wrong");
  stamp_now_a: assert property (
    tx_push && cur.tpos == POS_W'(TX_TS_POS) |->
    tx_in.data == local_time[31:24])
    else $error("timestamp not current time");
  time_step_a: assert property (
    tick && !rst |=> local_time == $past(local_time) + 32'h1)
    else $error("local time did not advance");
  rtt_calc_a: assert property (
    rpt_done |-> rpt_rtt == $past(local_time) - $past(cur.ts))
    else $error("round trip figure wrong");
  req_ignore_a: assert property (
    req_valid |-> (cur.rq_flag == REQ_FLAG_REGISTER && !req.deregister) ||
    (cur.rq_flag == REQ_FLAG_DEREGISTER && req.deregister))
    else $error("request flag decode wrong");
  rpt_len_a: assert property (
    rpt_valid |-> $past(cur.st) == RX_LO && $past(rx_valid))
    else $error("queue length out of place");
  rpt_unicast_a: assert property (
    rpt_done |-> !$past(rx_bcast) && $past(cur.opc) == OPC_REPORT)
    else $error("report accepted wrongly");
endmodule
`default_nettype wire

// [dv/mpcp_onu_model.sv]
// onu-side partner: sends reports and requests, sinks replies
// assumes the head codec octet streams and its single clock
`timescale 1ns/10ps
`default_nettype none
module mpcp_onu_model
  import mpcp_codec_pkg::*;
(
  input wire logic clk,
  input wire logic stall,
  input wire logic tx_valid,
  input wire byte_beat_t tx_beat,
  output logic tx_ready,
  output logic rx_valid,
  output byte_beat_t rx_beat,
  output logic rx_bcast
);
  byte_beat_t got[$];
  initial begin
    tx_ready = 1'b1;
    rx_valid = 1'b0;
    rx_beat = '0;
    rx_bcast = 1'b0;
  end
  // random stalls make the two-entry buffer fill and refuse
  always @(posedge clk) begin
    if (tx_valid && tx_ready)
      got.push_back(tx_beat);
    tx_ready <= !stall || 1'($urandom_range(1));
  end
  // idle data shows the inverse of the last octet, never a stale copy
  task automatic push(input logic [7:0] q[$], input logic bc);
    foreach (q[i]) begin
      @(posedge clk);
      rx_valid <= 1'b1;
      rx_beat <= '{data: q[i], last: i == q.size() - 1};
      rx_bcast <= bc;
    end
    @(posedge clk);
    rx_valid <= 1'b0;
    rx_beat <= '{data: ~q[q.size() - 1], last: 1'b0};
  endtask
  // sent on demand by the bench
  task automatic send_report(input logic [31:0] ts, input logic [7:0] maps[$],
      input logic [15:0] lens[$], input logic bc);
    logic [7:0] q[$];
    int k;
    q = {8'h00, 8'h03, ts[31:24], ts[23:16], ts[15:8], ts[7:0]};
    q.push_back(8'(maps.size()));
    k = 0;
    foreach (maps[s]) begin
      q.push_back(maps[s]);
      for (int n = 0; n < 8; n++)
        if (maps[s][n]) begin
          q.push_back(lens[k][15:8]);
          q.push_back(lens[k][7:0]);
          k++;
        end
    end
    while (q.size() < RX_LEN)
      q.push_back(8'h00);
    push(q, bc);
  endtask
  task automatic send_req(input logic [31:0] ts, input logic [7:0] flag, pd,
      input logic [15:0] disc, input logic [7:0] lon, loff, input logic bc);
    logic [7:0] q[$];
    q = {8'h00, 8'h04, ts[31:24], ts[23:16], ts[15:8], ts[7:0], flag, pd,
      disc[15:8], disc[7:0], lon, loff};
    while (q.size() < RX_LEN)
      q.push_back(8'h00);
    push(q, bc);
  endtask
endmodule
`default_nettype wire

// [dv/mpcp_report_register_codec_test.sv]
// self-checking bench for the head-end control frame codec
// assumes the onu model drives rx and sinks tx
`timescale 1ns/10ps
`default_nettype none
module mpcp_report_register_codec_test
  import mpcp_codec_pkg::*;
;
  logic clk, rst, cmd_go, cmd_busy, cmd_refused, tx_valid, tx_ready;
  logic rx_valid, rx_bcast, rpt_valid, rpt_done, req_valid, stall;
  byte_beat_t tx_beat, rx_beat;
  reg_cmd_t cmd;
  rpt_entry_t rpt;
  req_info_t req, last_req;
  logic [7:0] rpt_set_count;
  logic [31:0] rpt_rtt, local_time, done_time;
  rpt_entry_t ents[$];
  int n_mismatch = 0;
  int tests_run = 0;
  int n_done = 0;
  int n_req = 0;

  mpcp_head_codec #(.TQ_DIV(1), .BUF_DEPTH(2)) DUT (.clk(clk), .rst(rst),
    .cmd_go(cmd_go), .cmd(cmd), .cmd_busy(cmd_busy),
    .cmd_refused(cmd_refused), .tx_valid(tx_valid), .tx_beat(tx_beat),
    .tx_ready(tx_ready), .rx_valid(rx_valid), .rx_beat(rx_beat),
    .rx_bcast(rx_bcast), .rpt_valid(rpt_valid), .rpt(rpt),
    .rpt_done(rpt_done), .rpt_set_count(rpt_set_count), .rpt_rtt(rpt_rtt),
    .req_valid(req_valid), .req(req), .local_time(local_time));
  mpcp_onu_model u_onu (.clk(clk), .stall(stall), .tx_valid(tx_valid),
    .tx_beat(tx_beat), .tx_ready(tx_ready), .rx_valid(rx_valid),
    .rx_beat(rx_beat), .rx_bcast(rx_bcast));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  always @(posedge clk) begin
    if (rpt_valid)
      ents.push_back(rpt);
    if (rpt_done) begin
      n_done++;
      done_time = local_time;
    end
    if (req_valid) begin
      n_req++;
      last_req = req;
    end
  end

  task automatic final_report();
    $display("checks %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input string what, input logic [63:0] exp, got);
    tests_run++;
    if (exp !== got) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  function automatic logic [7:0] rbyte(reg_cmd_t c, int i);
    logic [159:0] h;
    h = {c.da, 16'h0005, 32'h0, c.port, c.flag, c.sync_time, c.pending,
      c.laser_on, c.laser_off};
    return i < 20 ? h[8 * (19 - i) +: 8] : 8'h00;
  endfunction

  // cmd_go held one edge too long must not start a second reply
  task automatic reply(input logic [7:0] flag, input logic grp);
    reg_cmd_t c;
    logic [31:0] ts;
    int i, nref;
    c = '{da: {16'($urandom), 32'($urandom)}, port: 16'($urandom),
      flag: flag, sync_time: 16'($urandom), pending: 8'($urandom),
      laser_on: 8'($urandom), laser_off: 8'($urandom)};
    c.da[DA_GROUP_BIT] = grp;
    u_onu.got.delete();
    nref = 0;
    @(posedge clk);
    cmd <= c;
    cmd_go <= 1'b1;
    @(posedge clk);
    cmd <= ~c;
    cmd_go <= !grp;
    @(posedge clk);
    nref += 32'(cmd_refused);
    chk("busy", 64'(!grp), 64'(cmd_busy));
    cmd_go <= 1'b0;
    for (i = 0; i < 3000 && (u_onu.got.size() < 52 || cmd_busy); i++) begin
      @(posedge clk);
      nref += 32'(cmd_refused);
      if (grp && i == 20)
        break;
    end
    if (i == 3000) begin
      n_mismatch++;
      final_report();
    end
    chk("refused pulses", 64'(grp), 64'(nref));
    chk("reply octets", grp ? 0 : 52, 64'(u_onu.got.size()));
    for (i = 0; i < u_onu.got.size(); i++) begin
      if (i < 8 || i > 11)
        chk("reply octet", rbyte(c, i), u_onu.got[i].data);
      chk("reply last", 64'(i == 51), 64'(u_onu.got[i].last));
    end
    if (!grp) begin
      ts = {u_onu.got[8].data, u_onu.got[9].data, u_onu.got[10].data,
        u_onu.got[11].data};
      chk("reply stamp age", 1, 64'(local_time - ts < 200));
    end
  endtask

  task automatic rpt_case(input logic [7:0] maps[$], input logic bc);
    logic [15:0] lens[$];
    rpt_entry_t e[$];
    logic [31:0] ts;
    int d0;
    ts = $urandom;
    foreach (maps[s])
      for (int n = 0; n < 8; n++)
        if (maps[s][n]) begin
          lens.push_back(16'($urandom));
          e.push_back('{set_idx: 8'(s), queue: 3'(n), length: lens[$]});
        end
    ents.delete();
    d0 = n_done;
    u_onu.send_report(ts, maps, lens, bc);
    repeat (2) @(posedge clk);
    chk("report done", 64'(!bc), 64'(n_done - d0));
    if (!bc) begin
      chk("set count", 64'(maps.size()), rpt_set_count);
      chk("rtt", 1, 64'(done_time - ts - rpt_rtt < 3));
    end
    chk("entries", 64'(e.size()), 64'(ents.size()));
    foreach (e[i])
      if (i < ents.size())
        chk("entry", e[i], ents[i]);
  endtask

  task automatic req_case(input logic [7:0] flag, input logic bc);
    logic [7:0] pd, on, off;
    logic [15:0] disc;
    logic ok;
    int r0;
    pd = 8'($urandom);
    on = 8'($urandom);
    off = 8'($urandom);
    disc = 16'($urandom);
    r0 = n_req;
    u_onu.send_req($urandom, flag, pd, disc, on, off, bc);
    repeat (2) @(posedge clk);
    ok = bc && (flag == 8'h01 || flag == 8'h03);
    chk("request taken", 64'(ok), 64'(n_req - r0));
    if (ok)
      chk("request fields", {flag == 8'h03, pd, disc[5], disc[4], disc[1],
        disc[0], on, off}, last_req);
  endtask

  initial begin
    logic [7:0] m[$];
    logic [7:0] fl[6] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'hff};
    rst = 1'b1;
    cmd_go = 1'b0;
    cmd = '0;
    stall = 1'b0;
    void'($urandom(50));
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    chk("idle after reset", 0, {cmd_busy, tx_valid, rpt_valid, req_valid});
    rpt_case('{8'hff, 8'hff, 8'h03}, 1'b0);
    rpt_case('{8'h80}, 1'b1);
    rpt_case('{8'h00, 8'h05}, 1'b0);
    for (int i = 0; i < 6; i++) begin
      m = {8'($urandom) | 8'h01, 8'($urandom) | 8'h10};
      rpt_case(m, 1'b0);
    end
    foreach (fl[i])
      req_case(fl[i], 1'b1);
    req_case(8'h01, 1'b0);
    stall <= 1'b1;
    for (int f = 1; f <= 4; f++)
      reply(8'(f), 1'b0);
    reply(8'h03, 1'b1);
    stall <= 1'b0;
    reply(8'h03, 1'b0);
    final_report();
  end
endmodule
`default_nettype wire
